// *** common/timing_route_defines.svh ***
// constants for the timing route and general-purpose line block
`ifndef TIMING_ROUTE_DEFINES_SVH
`define TIMING_ROUTE_DEFINES_SVH

// ========================================
// counts and widths
`define NUM_GP              8
`define NUM_FPIN            10
`define NUM_BUS             7
`define NUM_TIMING          13
`define SRC_SEL_W           5
`define BUS_SEL_W           3

// ========================================
// source select codes
`define SRC_BUS_BASE        5'h00
`define SRC_PIN_BASE        5'h07
`define SRC_PIN_LAST        5'h10
`define SRC_INT_A           5'h11
`define SRC_INT_B           5'h12
`define SRC_COUNT           5'h13

// ========================================
// fixed positions
`define COUNTER0_DIR_LINE   6
`define COUNTER1_DIR_LINE   7
`define SCAN_START_IDX      0
`define UPDATE_PIN          5
`define SCAN_START_PIN      7

// ========================================
// reset values
`define GP_OE_B_RST         8'hff
`define GP_OUT_RST          8'h00
`define FPIN_OE_B_RST       10'h3ff
`define BUS_OE_B_RST        7'h7f

// ========================================
// timing
`define SYS_CLK_HZ          25000000
`define INT_TIMEBASE_HZ     20000000

`endif

// *** common/timing_route_pkg.sv ***
// types for the timing route and general-purpose line block
`include "timing_route_defines.svh"

package timing_route_pkg;

	// ========================================
	// vectors
	typedef logic [`NUM_GP-1:0]                          gp_vec_t;
	typedef logic [`NUM_FPIN-1:0]                        fpin_vec_t;
	typedef logic [`NUM_BUS-1:0]                         bus_vec_t;
	typedef logic [`NUM_TIMING-1:0]                      timing_vec_t;
	typedef logic [`NUM_TIMING-1:1]                      int_src_t;
	typedef logic [`SRC_SEL_W-1:0]                       src_sel_t;
	typedef logic [`NUM_TIMING-1:0][`SRC_SEL_W-1:0]      timing_sel_arr_t;
	typedef logic [`NUM_BUS-1:0][`BUS_SEL_W-1:0]         bus_sel_arr_t;

	// ========================================
	// primary timebase source, one-hot
	typedef enum logic [1:0] {
		TB_INTERNAL = 2'h1,
		TB_BUS      = 2'h2
	} tb_src_t;

endpackage : timing_route_pkg

// *** core/bit_sync.sv ***
// two-flop level synchroniser, one per bit
`timescale 1ns/1ns

module bit_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	// data
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] hold_r;
	logic [WIDTH-1:0] hold_nxt;

	always_comb begin
		meta_nxt = i_d;
		hold_nxt = meta_r;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_r <= '0;
			hold_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign o_q = hold_r;

endmodule : bit_sync

// *** core/timing_route_and_gpio.sv ***
// general-purpose lines, timing source muxes, function pins, trigger bus and timebase
//
// What this block does
// - eight general-purpose lines, each with its own direction bit
// - reset leaves every general-purpose line undriven
// - line 6 feeds counter 0 direction, line 7 feeds counter 1
// - counter direction taps only sample the lines, never drive them
// - thirteen timing signals, each with its own software source mux
// - scan start picks bus lines, function pins, interval count or counter 0
// - every function pin reaches every mux; sharing a pin is allowed
// - each function pin has its own driver enable for its timing signal
// - software picks internal 20 MHz or bus timebase as primary
// - internal timebase may be driven onto the bus only while selected
// - after reset: internal timebase, bus timebase driver off
// - selected timebase clocks timing logic directly, no division
// - each bus line drives one of eight timing signals or is received
// - scan start pin pulses at each scan, rising edge marks start
// - update pin falls whenever the analog output group updates
`timescale 1ns/1ns
`include "timing_route_defines.svh"

module timing_route_and_gpio (
	// clocks and reset
	input  wire logic                              i_sys_clk,
	input  wire logic                              i_rst_b,
	input  wire logic                              i_int_timebase_clk,
	input  wire logic                              i_bus_timebase_clk,
	// general-purpose lines
	input  wire timing_route_pkg::gp_vec_t         i_gp_io_line_i,
	output timing_route_pkg::gp_vec_t              o_gp_io_line_o,
	output timing_route_pkg::gp_vec_t              o_gp_io_line_oe_b,
	input  wire timing_route_pkg::gp_vec_t         i_gp_dir,
	input  wire timing_route_pkg::gp_vec_t         i_gp_out,
	output timing_route_pkg::gp_vec_t              o_gp_in,
	output logic                                   o_counter0_direction_in,
	output logic                                   o_counter1_direction_in,
	// function pins
	input  wire timing_route_pkg::fpin_vec_t       i_function_pin_i,
	output timing_route_pkg::fpin_vec_t            o_function_pin_o,
	output timing_route_pkg::fpin_vec_t            o_function_pin_oe_b,
	input  wire timing_route_pkg::fpin_vec_t       i_function_pin_en,
	input  wire timing_route_pkg::fpin_vec_t       i_pin_signal,
	input  wire logic                              i_ao_update,
	// timing signal muxes
	input  wire timing_route_pkg::timing_sel_arr_t i_timing_sel,
	input  wire logic                              i_sample_interval_terminal_count,
	input  wire logic                              i_counter0_output,
	input  wire timing_route_pkg::int_src_t        i_int_src_a,
	input  wire timing_route_pkg::int_src_t        i_int_src_b,
	output timing_route_pkg::timing_vec_t          o_timing_signal,
	output logic                                   o_scan_start_pulse,
	// shared trigger bus lines
	input  wire timing_route_pkg::bus_vec_t        i_shared_trigger_bus_i,
	output timing_route_pkg::bus_vec_t             o_shared_trigger_bus_o,
	output timing_route_pkg::bus_vec_t             o_shared_trigger_bus_oe_b,
	input  wire timing_route_pkg::bus_vec_t        i_bus_line_en,
	input  wire timing_route_pkg::bus_sel_arr_t    i_bus_line_sel,
	// timebase
	input  wire logic                              i_timebase_sel_bus,
	input  wire logic                              i_timebase_drive,
	output logic                                   o_primary_timebase,
	output logic                                   o_bus_timebase_o,
	output logic                                   o_bus_timebase_oe_b
);
	import timing_route_pkg::*;

	// ========================================
	// pin synchronisers
	gp_vec_t     gp_s;
	fpin_vec_t   pin_s;
	bus_vec_t    bus_s;

	bit_sync #(.WIDTH(`NUM_GP)) u_gp_sync (
		.i_clk   (i_sys_clk),
		.i_rst_b (i_rst_b),
		.i_d     (i_gp_io_line_i),
		.o_q     (gp_s)
	);

	bit_sync #(.WIDTH(`NUM_FPIN)) u_pin_sync (
		.i_clk   (i_sys_clk),
		.i_rst_b (i_rst_b),
		.i_d     (i_function_pin_i),
		.o_q     (pin_s)
	);

	bit_sync #(.WIDTH(`NUM_BUS)) u_bus_sync (
		.i_clk   (i_sys_clk),
		.i_rst_b (i_rst_b),
		.i_d     (i_shared_trigger_bus_i),
		.o_q     (bus_s)
	);

	// ========================================
	// general-purpose lines
	gp_vec_t     gp_oe_b_r;
	gp_vec_t     gp_oe_b_nxt;
	gp_vec_t     gp_out_r;
	gp_vec_t     gp_out_nxt;

	always_comb begin
		gp_oe_b_nxt = ~i_gp_dir;
		gp_out_nxt  = i_gp_out;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gp_oe_b_r <= `GP_OE_B_RST;
			gp_out_r  <= `GP_OUT_RST;
		end else begin
			gp_oe_b_r <= gp_oe_b_nxt;
			gp_out_r  <= gp_out_nxt;
		end
	end

	assign o_gp_io_line_oe_b = gp_oe_b_r;
	assign o_gp_io_line_o    = gp_out_r;
	assign o_gp_in           = gp_s;
	// taps read the synchronised pin only
	assign o_counter0_direction_in = gp_s[`COUNTER0_DIR_LINE];
	assign o_counter1_direction_in = gp_s[`COUNTER1_DIR_LINE];

	// ========================================
	// timing signal source muxes
	timing_vec_t timing_r;
	timing_vec_t timing_nxt;
	logic [`NUM_TIMING-1:0] int_a;
	logic [`NUM_TIMING-1:0] int_b;

	assign int_a = {i_int_src_a, i_sample_interval_terminal_count};
	assign int_b = {i_int_src_b, i_counter0_output};

	always_comb begin
		logic [`SRC_COUNT-1:0] src;
		src        = '0;
		timing_nxt = '0;
		for (int k = 0; k < `NUM_TIMING; k++) begin
			// same pin vector feeds every mux
			src = {int_b[k], int_a[k], pin_s, bus_s};
			if (i_timing_sel[k] < `SRC_COUNT) begin
				timing_nxt[k] = src[i_timing_sel[k]];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			timing_r <= '0;
		end else begin
			timing_r <= timing_nxt;
		end
	end

	assign o_timing_signal    = timing_r;
	assign o_scan_start_pulse = timing_r[`SCAN_START_IDX];

	// ========================================
	// function pin drivers
	fpin_vec_t   pin_o_r;
	fpin_vec_t   pin_o_nxt;
	fpin_vec_t   pin_oe_b_r;
	fpin_vec_t   pin_oe_b_nxt;

	always_comb begin
		pin_o_nxt                  = i_pin_signal;
		pin_o_nxt[`SCAN_START_PIN] = timing_nxt[`SCAN_START_IDX];
		pin_o_nxt[`UPDATE_PIN]     = ~i_ao_update;
		pin_oe_b_nxt               = ~i_function_pin_en;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_o_r    <= '0;
			pin_oe_b_r <= `FPIN_OE_B_RST;
		end else begin
			pin_o_r    <= pin_o_nxt;
			pin_oe_b_r <= pin_oe_b_nxt;
		end
	end

	assign o_function_pin_o    = pin_o_r;
	assign o_function_pin_oe_b = pin_oe_b_r;

	// ========================================
	// trigger bus drive, system side
	bus_vec_t    bus_val_r;
	bus_vec_t    bus_val_nxt;
	bus_vec_t    bus_en_r;
	bus_vec_t    bus_en_nxt;

	always_comb begin
		for (int j = 0; j < `NUM_BUS; j++) begin
			bus_val_nxt[j] = timing_r[i_bus_line_sel[j]];
		end
		bus_en_nxt = i_bus_line_en;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bus_val_r <= '0;
			bus_en_r  <= '0;
		end else begin
			bus_val_r <= bus_val_nxt;
			bus_en_r  <= bus_en_nxt;
		end
	end

	// ========================================
	// trigger bus drive, link side
	bus_vec_t    link_val_s;
	bus_vec_t    link_en_s;
	bus_vec_t    link_o_r;
	bus_vec_t    link_o_nxt;
	bus_vec_t    link_oe_b_r;
	bus_vec_t    link_oe_b_nxt;

	bit_sync #(.WIDTH(2 * `NUM_BUS)) u_link_sync (
		.i_clk   (i_bus_timebase_clk),
		.i_rst_b (i_rst_b),
		.i_d     ({bus_en_r, bus_val_r}),
		.o_q     ({link_en_s, link_val_s})
	);

	always_comb begin
		link_o_nxt    = link_val_s;
		link_oe_b_nxt = ~link_en_s;
	end

	always_ff @(posedge i_bus_timebase_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			link_o_r    <= '0;
			link_oe_b_r <= `BUS_OE_B_RST;
		end else begin
			link_o_r    <= link_o_nxt;
			link_oe_b_r <= link_oe_b_nxt;
		end
	end

	assign o_shared_trigger_bus_o    = link_o_r;
	assign o_shared_trigger_bus_oe_b = link_oe_b_r;

	// ========================================
	// primary timebase
	tb_src_t     tb_src_r;
	tb_src_t     tb_src_nxt;
	logic        tb_oe_b_r;
	logic        tb_oe_b_nxt;

	always_comb begin
		tb_src_nxt  = i_timebase_sel_bus ? TB_BUS : TB_INTERNAL;
		// drive only while internal is both held and requested
		tb_oe_b_nxt = ~(i_timebase_drive && !i_timebase_sel_bus && (tb_src_r == TB_INTERNAL));
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tb_src_r  <= TB_INTERNAL;
			tb_oe_b_r <= 1'b1;
		end else begin
			tb_src_r  <= tb_src_nxt;
			tb_oe_b_r <= tb_oe_b_nxt;
		end
	end

	// clock path, no divider; switching may glitch, change only while idle
	assign o_primary_timebase  = (tb_src_r == TB_BUS) ? i_bus_timebase_clk : i_int_timebase_clk;
	assign o_bus_timebase_o    = i_int_timebase_clk;
	assign o_bus_timebase_oe_b = tb_oe_b_r;

	// ========================================
	// assertions
	property p_gp_all_inputs;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_gp_dir == 8'h00) |=> (o_gp_io_line_oe_b == 8'hff);
	endproperty
	a_gp_all_inputs: assert property (p_gp_all_inputs) else $error("gp line driven while input");

	property p_gp_reset_hiz;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(i_rst_b) |-> (o_gp_io_line_oe_b == 8'hff);
	endproperty
	a_gp_reset_hiz: assert property (p_gp_reset_hiz) else $error("gp line driven after reset");

	property p_counter0_tap;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(i_rst_b) ##2 1'b1 |-> (o_counter0_direction_in == $past(i_gp_io_line_i[6], 2));
	endproperty
	a_counter0_tap: assert property (p_counter0_tap) else $error("counter 0 tap wrong");

	property p_tap_passive;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		($past(i_rst_b) && $stable({i_gp_dir, i_gp_out})) |=> $stable({o_gp_io_line_oe_b, o_gp_io_line_o});
	endproperty
	a_tap_passive: assert property (p_tap_passive) else $error("gp line changed on its own");

	property p_pin_source;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_timing_sel[3] == 5'h09) |=> (o_timing_signal[3] == $past(pin_s[2]));
	endproperty
	a_pin_source: assert property (p_pin_source) else $error("timing mux pin source wrong");

	property p_scan_interval;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_timing_sel[0] == 5'h11) |=> (o_scan_start_pulse == $past(i_sample_interval_terminal_count));
	endproperty
	a_scan_interval: assert property (p_scan_interval) else $error("scan start source wrong");

	property p_shared_pin;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_timing_sel[1] == i_timing_sel[2] && i_timing_sel[1] >= 5'h07 && i_timing_sel[1] <= 5'h10)
		|=> (o_timing_signal[1] == o_timing_signal[2]);
	endproperty
	a_shared_pin: assert property (p_shared_pin) else $error("shared pin gave different values");

	property p_pin_driver_off;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_function_pin_en == 10'h000) |=> (o_function_pin_oe_b == 10'h3ff);
	endproperty
	a_pin_driver_off: assert property (p_pin_driver_off) else $error("function pin driven while off");

	property p_tb_no_drive_on_bus;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(tb_src_r == TB_BUS) |-> o_bus_timebase_oe_b;
	endproperty
	a_tb_no_drive_on_bus: assert property (p_tb_no_drive_on_bus) else $error("timebase driven from bus");

	property p_tb_reset_default;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(i_rst_b) |-> (tb_src_r == TB_INTERNAL && o_bus_timebase_oe_b);
	endproperty
	a_tb_reset_default: assert property (p_tb_reset_default) else $error("timebase default wrong");

	property p_bus_line_drive;
		@(posedge i_bus_timebase_clk) disable iff (!i_rst_b)
		link_en_s[0] |=> (!o_shared_trigger_bus_oe_b[0] && o_shared_trigger_bus_o[0] == $past(link_val_s[0]));
	endproperty
	a_bus_line_drive: assert property (p_bus_line_drive) else $error("bus line drive wrong");

	property p_scan_pin;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_scan_start_pulse) |-> $rose(o_function_pin_o[7]);
	endproperty
	a_scan_pin: assert property (p_scan_pin) else $error("scan pin edge missing");

	property p_update_pin;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(i_ao_update) |=> $fell(o_function_pin_o[5]);
	endproperty
	a_update_pin: assert property (p_update_pin) else $error("update pin edge missing");

	property p_reset_drivers_off;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(i_rst_b) |-> (o_function_pin_oe_b == 10'h3ff);
	endproperty
	a_reset_drivers_off: assert property (p_reset_drivers_off) else $error("pin driver on after reset");

	c_scan_from_pin: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_timing_sel[0] == 5'h0e) ##1 $rose(o_scan_start_pulse));
	c_tb_drive: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$fell(o_bus_timebase_oe_b));
	c_bus_drive: cover property (@(posedge i_bus_timebase_clk) disable iff (!i_rst_b)
		$fell(o_shared_trigger_bus_oe_b[0]));

endmodule : timing_route_and_gpio

// *** testbench/ext_side_model.sv ***
// far-side model: external circuitry, other boards, bus timebase clock
`timescale 1ns/1ns
`include "timing_route_defines.svh"

module ext_side_model (
	// clock
	input  wire logic                        i_sys_clk,
	// design drivers
	input  wire timing_route_pkg::gp_vec_t   i_gp_o,
	input  wire timing_route_pkg::gp_vec_t   i_gp_oe_b,
	input  wire timing_route_pkg::fpin_vec_t i_fp_o,
	input  wire timing_route_pkg::fpin_vec_t i_fp_oe_b,
	input  wire timing_route_pkg::bus_vec_t  i_bus_o,
	input  wire timing_route_pkg::bus_vec_t  i_bus_oe_b,
	input  wire logic                        i_tb_o,
	input  wire logic                        i_tb_oe_b,
	// far-side drive requests
	input  wire timing_route_pkg::gp_vec_t   i_gp_ext,
	input  wire timing_route_pkg::gp_vec_t   i_gp_ext_en,
	input  wire timing_route_pkg::fpin_vec_t i_fp_ext,
	input  wire timing_route_pkg::fpin_vec_t i_fp_ext_en,
	input  wire timing_route_pkg::bus_vec_t  i_bus_ext,
	input  wire timing_route_pkg::bus_vec_t  i_bus_ext_en,
	// resolved lines
	output timing_route_pkg::gp_vec_t        o_gp_line,
	output timing_route_pkg::fpin_vec_t      o_fp_line,
	output timing_route_pkg::bus_vec_t       o_bus_line,
	output logic                             o_tb_line
);
	import timing_route_pkg::*;

	logic link_clk;
	logic tog = 1'b0;

	// ========================================
	// free-running timebase of another board, 15 ns
	initial begin
		link_clk = 1'b0;
		#3;
		forever begin
			#8 link_clk = ~link_clk;
			#7 link_clk = ~link_clk;
		end
	end

	// released bus lines have no pull, so show a changing pattern
	always @(posedge i_sys_clk) tog <= ~tog;

	// ========================================
	// line resolution, pull-ups on gp and function lines
	assign o_gp_line  = (~i_gp_oe_b & i_gp_o) | (i_gp_oe_b & i_gp_ext_en & i_gp_ext) | (i_gp_oe_b & ~i_gp_ext_en);
	assign o_fp_line  = (~i_fp_oe_b & i_fp_o) | (i_fp_oe_b & i_fp_ext_en & i_fp_ext) | (i_fp_oe_b & ~i_fp_ext_en);
	assign o_bus_line = (~i_bus_oe_b & i_bus_o) | (i_bus_oe_b & i_bus_ext_en & i_bus_ext)
		| (i_bus_oe_b & ~i_bus_ext_en & {`NUM_BUS{tog}});
	assign o_tb_line  = i_tb_oe_b ? link_clk : i_tb_o;
endmodule : ext_side_model

// *** testbench/timing_route_and_gpio_tb_top.sv ***
// self-checking bench for the timing route and general-purpose line block
`timescale 1ns/1ns
`include "timing_route_defines.svh"

module timing_route_and_gpio_tb_top;
	import timing_route_pkg::*;

	typedef struct {gp_vec_t dir; gp_vec_t out; gp_vec_t ext; gp_vec_t lvl;} gp_row_t;

	logic            sys_clk, rst_b, int_clk, c0_dir, c1_dir, ao_upd, tc, c0_out, scan;
	logic            tb_sel_bus, tb_drive, prim_tb, tb_o, tb_oe_b, tb_line;
	gp_vec_t         gp_dir, gp_out, gp_ext, gp_ext_en, gp_line, gp_o, gp_oe_b, gp_in;
	fpin_vec_t       fp_ext, fp_ext_en, fp_line, fp_o, fp_oe_b, fp_en, pin_sig;
	bus_vec_t        bus_ext, bus_ext_en, bus_line, bus_o, bus_oe_b, bus_en;
	timing_sel_arr_t tsel;
	bus_sel_arr_t    bus_sel;
	int_src_t        src_a, src_b;
	timing_vec_t     tsig;
	int              num_errors, cmp_count;
	gp_row_t         rows [4] = '{'{8'h0f, 8'h05, 8'hc0, 8'hc5}, '{8'hf0, 8'h80, 8'h0a, 8'h8a},
		'{8'h00, 8'hff, 8'h40, 8'h40}, '{8'hff, 8'h3c, 8'h00, 8'h3c}};

	timing_route_and_gpio u_timing_route_and_gpio (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
		.i_int_timebase_clk(int_clk), .i_bus_timebase_clk(tb_line), .i_gp_io_line_i(gp_line),
		.o_gp_io_line_o(gp_o), .o_gp_io_line_oe_b(gp_oe_b), .i_gp_dir(gp_dir), .i_gp_out(gp_out),
		.o_gp_in(gp_in), .o_counter0_direction_in(c0_dir), .o_counter1_direction_in(c1_dir),
		.i_function_pin_i(fp_line), .o_function_pin_o(fp_o), .o_function_pin_oe_b(fp_oe_b),
		.i_function_pin_en(fp_en), .i_pin_signal(pin_sig), .i_ao_update(ao_upd), .i_timing_sel(tsel),
		.i_sample_interval_terminal_count(tc), .i_counter0_output(c0_out), .i_int_src_a(src_a),
		.i_int_src_b(src_b), .o_timing_signal(tsig), .o_scan_start_pulse(scan),
		.i_shared_trigger_bus_i(bus_line), .o_shared_trigger_bus_o(bus_o),
		.o_shared_trigger_bus_oe_b(bus_oe_b), .i_bus_line_en(bus_en), .i_bus_line_sel(bus_sel),
		.i_timebase_sel_bus(tb_sel_bus), .i_timebase_drive(tb_drive), .o_primary_timebase(prim_tb),
		.o_bus_timebase_o(tb_o), .o_bus_timebase_oe_b(tb_oe_b));

	ext_side_model u_ext_side_model (.i_sys_clk(sys_clk), .i_gp_o(gp_o), .i_gp_oe_b(gp_oe_b),
		.i_fp_o(fp_o), .i_fp_oe_b(fp_oe_b), .i_bus_o(bus_o), .i_bus_oe_b(bus_oe_b), .i_tb_o(tb_o),
		.i_tb_oe_b(tb_oe_b), .i_gp_ext(gp_ext), .i_gp_ext_en(gp_ext_en), .i_fp_ext(fp_ext),
		.i_fp_ext_en(fp_ext_en), .i_bus_ext(bus_ext), .i_bus_ext_en(bus_ext_en),
		.o_gp_line(gp_line), .o_fp_line(fp_line), .o_bus_line(bus_line), .o_tb_line(tb_line));

	// ========================================
	// clocks and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		int_clk = 1'b0;
		forever #25 int_clk = ~int_clk;
	end
	initial begin
		#100000;
		num_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		tally_and_finish();
	end

	// ========================================
	// helpers
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	// one source high: 0-6 bus, 7-16 pins, 17 count, 18 counter 0, 19 all
	task automatic set_src(input int k, input logic v);
		bus_ext = '0;
		fp_ext = '0;
		tc = 1'b0;
		c0_out = 1'b0;
		if (k < 7) bus_ext[k] = v;
		else if (k < 17) fp_ext[k - 7] = v;
		else if (k == 17) tc = v;
		else if (k == 18) c0_out = v;
		else {bus_ext, fp_ext, tc, c0_out} = {19{v}};
	endtask : set_src

	task automatic follow(input logic use_bus);
		repeat (4) begin
			if (use_bus) @(tb_line);
			else @(int_clk);
			#1;
			check(16'(prim_tb), 16'(use_bus ? tb_line : int_clk), "timebase");
			if (!use_bus) check(16'(tb_o), 16'(int_clk), "timebase out");
		end
		cyc(1);
	endtask : follow

	task automatic rst_chk;
		check(16'(gp_oe_b), 16'h00ff, "gp oe in reset");
		check(16'(fp_oe_b), 16'h03ff, "pin oe in reset");
		check(16'(bus_oe_b), 16'h007f, "bus oe in reset");
		check(16'(tb_oe_b), 16'h0001, "timebase oe in reset");
	endtask : rst_chk

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// ========================================
	// main sequence
	initial begin
		gp_vec_t     e;
		timing_vec_t tv;
		{rst_b, ao_upd, tc, c0_out, tb_sel_bus, tb_drive} = '0;
		{gp_dir, gp_out, gp_ext, fp_ext, fp_en, pin_sig, bus_ext, bus_en} = '0;
		{tsel, bus_sel, src_a, src_b} = '0;
		{gp_ext_en, fp_ext_en, bus_ext_en} = '1;
		num_errors = 0;
		cmp_count = 0;
		cyc(6);
		rst_chk();
		rst_b = 1'b1;
		cyc(2);
		follow(1'b0);
		foreach (rows[i]) begin
			gp_dir = rows[i].dir;
			gp_out = rows[i].out;
			gp_ext = rows[i].ext;
			gp_ext_en = ~rows[i].dir;
			e = ~rows[i].dir;
			cyc(4);
			check(16'(gp_oe_b), 16'(e), "gp oe");
			check(16'(gp_o & rows[i].dir), 16'(rows[i].out & rows[i].dir), "gp out");
			check(16'(gp_in), 16'(rows[i].lvl), "gp in");
			check(16'({c1_dir, c0_dir}), 16'(rows[i].lvl[7:6]), "direction taps");
		end
		for (int k = 0; k <= 19; k++) begin
			tsel[0] = 5'(k);
			set_src(k, 1'b0);
			cyc(4);
			check(16'(tsig[0]), 16'h0000, "scan mux low");
			set_src(k, 1'b1);
			cyc(4);
			check(16'(tsig[0]), 16'(k < 19), "scan mux high");
		end
		for (int v = 0; v < 2; v++) begin
			tsel = {`NUM_TIMING{`SRC_PIN_BASE + 5'h04}};
			set_src(11, v[0]);
			cyc(4);
			check(16'(tsig), v[0] ? 16'h1fff : 16'h0000, "shared pin");
		end
		tsel[3] = `SRC_PIN_BASE + 5'h02;
		set_src(9, 1'b1);
		cyc(4);
		check(16'(tsig[3]), 16'h0001, "pin 2 source");
		tsel = {`NUM_TIMING{`SRC_INT_B}};
		src_b = 12'ha5a;
		c0_out = 1'b1;
		cyc(2);
		check(16'(tsig), {3'b000, 12'ha5a, 1'b1}, "internal sources");
		fp_en = 10'h0a8;
		fp_ext_en = 10'h357;
		pin_sig = 10'h008;
		tsel[0] = `SRC_INT_A;
		cyc(2);
		check(16'(fp_oe_b), 16'h0357, "pin oe");
		check(16'(fp_o[3]), 16'h0001, "pin drive");
		check(16'(fp_o[5]), 16'h0001, "update idle");
		ao_upd = 1'b1;
		tc = 1'b1;
		pin_sig = 10'h000;
		cyc(1);
		check(16'(fp_o[5]), 16'h0000, "update falls");
		check(16'({fp_o[7], scan}), 16'h0003, "scan start rises");
		check(16'(fp_o[3]), 16'h0000, "pin drive low");
		ao_upd = 1'b0;
		tc = 1'b0;
		cyc(1);
		check(16'({fp_o[7], scan, fp_o[5]}), 16'h0001, "single pulse");
		tsel = {`NUM_TIMING{`SRC_INT_A}};
		src_a = 12'h5a3;
		tc = 1'b1;
		tv = {12'h5a3, 1'b1};
		for (int j = 0; j < `NUM_BUS; j++) bus_sel[j] = 3'(j);
		bus_en = '1;
		bus_ext_en = '0;
		cyc(10);
		check(16'(bus_oe_b), 16'h0000, "bus oe");
		check(16'(bus_line), 16'(tv[6:0]), "bus lines");
		bus_sel = {`NUM_BUS{3'h7}};
		cyc(10);
		check(16'(bus_o), 16'({`NUM_BUS{tv[7]}}), "bus timing 7");
		tb_drive = 1'b1;
		cyc(2);
		check(16'(tb_oe_b), 16'h0000, "timebase driven");
		tb_sel_bus = 1'b1;
		cyc(2);
		check(16'(tb_oe_b), 16'h0001, "drive refused");
		follow(1'b1);
		tb_sel_bus = 1'b0;
		cyc(3);
		check(16'(tb_oe_b), 16'h0000, "drive again");
		follow(1'b0);
		gp_dir = '1;
		fp_en = '1;
		cyc(4);
		rst_b = 1'b0;
		#1;
		rst_chk();
		cyc(6);
		rst_b = 1'b1;
		cyc(2);
		check(16'(gp_oe_b), 16'h0000, "gp oe after reset");
		check(16'(fp_oe_b), 16'h0000, "pin oe after reset");
		tally_and_finish();
	end
endmodule : timing_route_and_gpio_tb_top
